// ===== pkg/pie_pkg.sv
// constants for the second peripheral interrupt enable register
// assumes an 8-bit banked data memory with a 4-bit bank select
package pie_pkg;
  localparam logic [7:0] PIE_ADDR = 8'h11;
  localparam logic [3:0] PIE_BANK = 4'h4;
  localparam logic [7:0] PIE_RESET = 8'h00;
  localparam logic [7:0] PIE_IMPL_MASK = 8'hEF;
  localparam int PIE_BIT_SERIAL = 7;
  localparam int PIE_BIT_COLL = 6;
  localparam int PIE_BIT_CONV = 5;
  localparam int PIE_BIT_UNUSED = 4;
  localparam int PIE_BIT_CAP4 = 3;
  localparam int PIE_BIT_CAP3 = 2;
  localparam int PIE_BIT_TX = 1;
  localparam int PIE_BIT_RX = 0;
endpackage

// ===== rtl/pie_gate.sv
// gates peripheral flags by their enables and registers the result
// assumes flags and enables are on the core clock
module pie_gate
  import pie_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] flag,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] request,
  output logic any_request
);
  // a request passes only when flag and enable are both set
  wire [WIDTH-1:0] gated = flag & enable; // RULE11

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      request <= '0;
      any_request <= 1'h0;
    end else begin
      request <= gated;
      any_request <= |gated;
    end
  end
endmodule

// ===== rtl/pie_bank2.sv
// second peripheral interrupt enable register with request gating
// assumes a core bus with bank select, address, write and read strobes
// Functional notes
// RULE1: register at address 11h, bank 4
// RULE2: implemented enables clear at power-on reset
// RULE3: bit 7 enables serial port interrupt
// RULE4: bit 6 enables bus collision interrupt
// RULE5: bit 5 enables converter interrupt
// RULE6: bit 4 reads zero, ignores writes
// RULE7: bit 3 enables capture four interrupt
// RULE8: bit 1 enables uart b transmit interrupt
// RULE9: bit 0 enables uart b receive interrupt
// RULE10: bit 2 enables capture three interrupt
// RULE11: request needs both flag and enable
module pie_bank2
  import pie_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] bank_sel,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] irq_flags,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic [7:0] irq_request,
  output logic irq_any,
  output logic serial_port_irq_enable,
  output logic bus_collision_irq_enable,
  output logic converter_irq_enable,
  output logic capture_four_irq_enable,
  output logic capture_three_irq_enable,
  output logic uart_b_transmit_irq_enable,
  output logic uart_b_receive_irq_enable
);
  logic [7:0] peripheral_irq_enable_second_reg;
  logic [7:0] peripheral_irq_enable_second_next;
  logic [7:0] rd_data_next;

  // keeps the implemented bits only; bit 4 can never hold or read a one
  function automatic logic [7:0] impl_bits(input logic [7:0] value);
    return value & PIE_IMPL_MASK;
  endfunction

  // true when bank and address both name this register
  function automatic logic reg_match(input logic [3:0] bank,
    input logic [7:0] address);
    return (bank == PIE_BANK) && (address == PIE_ADDR);
  endfunction

  // decode: both bank and address must match
  wire hit = reg_match(bank_sel, addr); // RULE1
  wire wr_hit = hit && wr_en;
  wire rd_sel = hit && rd_en;

  // unimplemented bit masked on write so it never holds a one
  assign peripheral_irq_enable_second_next =
    wr_hit ? impl_bits(wr_data) : peripheral_irq_enable_second_reg; // RULE6
  // read returns the value held before a write in the same cycle
  assign rd_data_next =
    rd_sel ? impl_bits(peripheral_irq_enable_second_reg) : 8'h00; // RULE6

  // enable storage, all sources disabled after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_enable_second_reg <= PIE_RESET; // RULE2
    end else begin // RULE3 RULE4 RULE5 RULE7 RULE8 RULE9 RULE10
      peripheral_irq_enable_second_reg <= peripheral_irq_enable_second_next;
    end
  end

  // registered read port; data is zero when not selected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_hit <= 1'h0;
    end else begin
      rd_data <= rd_data_next;
      rd_hit <= rd_sel;
    end
  end

  // per-source enables, taken straight from the register flops
  assign serial_port_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_SERIAL]; // RULE3
  assign bus_collision_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_COLL]; // RULE4
  assign converter_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_CONV]; // RULE5
  assign capture_four_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_CAP4]; // RULE7
  assign capture_three_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_CAP3]; // RULE10
  assign uart_b_transmit_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_TX]; // RULE8
  assign uart_b_receive_irq_enable =
    peripheral_irq_enable_second_reg[PIE_BIT_RX]; // RULE9

  // gating adds one cycle of latency but keeps outputs registered
  pie_gate #(.WIDTH(8)) u_gate (
    .clock(clock),
    .rst_n(rst_n),
    .flag(irq_flags),
    .enable(peripheral_irq_enable_second_reg),
    .request(irq_request),
    .any_request(irq_any)
  );

  // write path: the whole stored value after a selected write
  a_write_stores: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit |=> peripheral_irq_enable_second_reg == impl_bits($past(wr_data)))
    else $error("enable write not stored"); // RULE3

  // each implemented enable follows its written bit, both ways
  a_serial_set: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_SERIAL]) |=> serial_port_irq_enable)
    else $error("serial port enable not set"); // RULE3

  a_serial_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_SERIAL]) |=> !serial_port_irq_enable)
    else $error("serial port enable not cleared"); // RULE3

  a_coll_set: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_COLL]) |=> bus_collision_irq_enable)
    else $error("bus collision enable not set"); // RULE4

  a_coll_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_COLL]) |=> !bus_collision_irq_enable)
    else $error("bus collision enable not cleared"); // RULE4

  a_conv_set: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_CONV]) |=> converter_irq_enable)
    else $error("converter enable not set"); // RULE5

  a_conv_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_CONV]) |=> !converter_irq_enable)
    else $error("converter enable not cleared"); // RULE5

  a_cap4_set: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_CAP4]) |=> capture_four_irq_enable)
    else $error("capture four enable not set"); // RULE7

  a_cap4_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_CAP4]) |=> !capture_four_irq_enable)
    else $error("capture four enable not cleared"); // RULE7

  a_cap3_set: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_CAP3]) |=> capture_three_irq_enable)
    else $error("capture three enable not set"); // RULE10

  a_cap3_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_CAP3]) |=> !capture_three_irq_enable)
    else $error("capture three enable not cleared"); // RULE10

  a_tx_enable: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_TX]) |=> uart_b_transmit_irq_enable)
    else $error("transmit enable not set"); // RULE8

  a_tx_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_TX]) |=> !uart_b_transmit_irq_enable)
    else $error("transmit enable not cleared"); // RULE8

  a_rx_set: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_RX]) |=> uart_b_receive_irq_enable)
    else $error("receive enable not set"); // RULE9

  a_rx_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && !wr_data[PIE_BIT_RX]) |=> !uart_b_receive_irq_enable)
    else $error("receive enable not cleared"); // RULE9

  // unimplemented bit: never stored, never read, never requested
  a_unused_zero: assert property (@(posedge clock) disable iff (!rst_n)
    !peripheral_irq_enable_second_reg[PIE_BIT_UNUSED] &&
    !rd_data[PIE_BIT_UNUSED])
    else $error("unused bit not zero"); // RULE6

  a_write_unused: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_hit && wr_data[PIE_BIT_UNUSED]) |=>
    !peripheral_irq_enable_second_reg[PIE_BIT_UNUSED])
    else $error("write to unused bit took effect"); // RULE6

  a_req_unused: assert property (@(posedge clock) disable iff (!rst_n)
    !irq_request[PIE_BIT_UNUSED])
    else $error("request on unused bit"); // RULE6

  // decode: only bank 4, address 11h may change or show the register
  a_hold_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    !wr_hit |=> $stable(peripheral_irq_enable_second_reg))
    else $error("enable changed without write"); // RULE1

  a_wrong_bank: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && bank_sel != PIE_BANK) |=>
    $stable(peripheral_irq_enable_second_reg))
    else $error("write in other bank took effect"); // RULE1

  a_miss_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_en && !reg_match(bank_sel, addr)) |=>
    $stable(peripheral_irq_enable_second_reg))
    else $error("write to other address took effect"); // RULE1

  a_read_value: assert property (@(posedge clock) disable iff (!rst_n)
    rd_sel |=> rd_data == $past(peripheral_irq_enable_second_reg))
    else $error("read value wrong"); // RULE10

  a_read_hit: assert property (@(posedge clock) disable iff (!rst_n)
    rd_sel |=> rd_hit)
    else $error("read hit missing"); // RULE1

  a_idle_data: assert property (@(posedge clock) disable iff (!rst_n)
    !rd_sel |=> rd_data == 8'h00)
    else $error("read data shown without read"); // RULE1

  a_idle_hit: assert property (@(posedge clock) disable iff (!rst_n)
    !rd_sel |=> !rd_hit)
    else $error("read hit without read"); // RULE1

  // gating: a request needs its flag and its enable together
  a_gate_and: assert property (@(posedge clock) disable iff (!rst_n)
    1'h1 |=> irq_request ==
    ($past(irq_flags) & $past(peripheral_irq_enable_second_reg)))
    else $error("request gating wrong"); // RULE11

  a_req_blocked: assert property (@(posedge clock) disable iff (!rst_n)
    1'h1 |=> (irq_request & ~$past(peripheral_irq_enable_second_reg)) ==
    8'h00)
    else $error("request passed a cleared enable"); // RULE11

  a_any_req: assert property (@(posedge clock) disable iff (!rst_n)
    irq_any == (irq_request != 8'h00))
    else $error("summary request mismatch"); // RULE11

  a_any_flags: assert property (@(posedge clock) disable iff (!rst_n)
    1'h1 |=> irq_any ==
    |($past(irq_flags) & $past(peripheral_irq_enable_second_reg)))
    else $error("summary request not from flags"); // RULE11
endmodule

// ===== bench/pie_bank2_tb_top.sv
// self-checking bench for the second interrupt enable register
// assumes pie_bank2 and pie_pkg compiled first; bench drives all ports
module pie_bank2_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pie_pkg::*;
  logic clock = 0;
  logic rst_n = 0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic [3:0] bank_sel = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] irq_flags = 8'h00;
  logic [7:0] rd_data, irq_request;
  logic rd_hit, irq_any, e7, e6, e5, e3, e2, e1, e0;
  int n_mismatch = 0;
  int tests_run = 0;
  wire [7:0] en = {e7, e6, e5, 1'b0, e3, e2, e1, e0};
  // 40 MHz core clock
  always #12.5 clock = ~clock;
  pie_bank2 u_pie_bank2 (.clock(clock), .rst_n(rst_n), .bank_sel(bank_sel),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
    .irq_flags(irq_flags), .rd_data(rd_data), .rd_hit(rd_hit),
    .irq_request(irq_request), .irq_any(irq_any),
    .serial_port_irq_enable(e7), .bus_collision_irq_enable(e6),
    .converter_irq_enable(e5), .capture_four_irq_enable(e3),
    .capture_three_irq_enable(e2), .uart_b_transmit_irq_enable(e1),
    .uart_b_receive_irq_enable(e0));
  // case equality so an unknown never passes
  task chk(string n, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  // one strobed access; strobes drop after the taking edge
  task acc(logic w, logic [3:0] b, logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    wr_en <= w;
    rd_en <= !w;
    bank_sel <= b;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
  endtask
  // walk a single one through every bit, bit 4 must never stick
  task t_bits;
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, PIE_BANK, PIE_ADDR, 8'h01 << i);
      chk("enables", (8'h01 << i) & 8'hEF, en);
      acc(1'b0, PIE_BANK, PIE_ADDR, 8'h00);
      chk("rd_data", (8'h01 << i) & 8'hEF, rd_data);
      chk("rd_hit", 8'h01, {7'h00, rd_hit});
    end
  endtask
  // near misses on bank or address must leave the register alone
  task t_decode;
    acc(1'b1, PIE_BANK, PIE_ADDR, 8'h21);
    acc(1'b1, PIE_BANK ^ 4'h1, PIE_ADDR, 8'hFF);
    acc(1'b1, PIE_BANK, PIE_ADDR + 8'h01, 8'hFF);
    chk("enables", 8'h21, en);
    acc(1'b0, PIE_BANK ^ 4'h1, PIE_ADDR, 8'h00);
    chk("rd_hit", 8'h00, {7'h00, rd_hit});
    chk("rd_data", 8'h00, rd_data);
  endtask
  // request only where flag and enable are both set
  task t_gate;
    acc(1'b1, PIE_BANK, PIE_ADDR, 8'hFF);
    @(posedge clock);
    irq_flags <= 8'h5A;
    repeat (2) @(posedge clock);
    #1;
    chk("irq_request", 8'h4A, irq_request);
    chk("irq_any", 8'h01, {7'h00, irq_any});
    acc(1'b1, PIE_BANK, PIE_ADDR, 8'hA5);
    repeat (2) @(posedge clock);
    #1;
    chk("irq_request", 8'h00, irq_request);
    chk("irq_any", 8'h00, {7'h00, irq_any});
  endtask
  // reset in mid-run clears every enable and the gated requests
  task t_reset;
    acc(1'b1, PIE_BANK, PIE_ADDR, 8'hFF);
    chk("enables", 8'hEF, en);
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    chk("reset enables", PIE_RESET, en);
    chk("reset irq_request", 8'h00, irq_request);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("reset enables", PIE_RESET, en);
    acc(1'b1, PIE_BANK, PIE_ADDR, 8'h03);
    chk("enables", 8'h03, en);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("reset enables", PIE_RESET, en);
    t_bits();
    t_decode();
    t_gate();
    t_reset();
    stop_test();
  end
  // watchdog, run needs about 70 cycles; 800 allowed
  initial begin
    #20us;
    n_mismatch++;
    stop_test();
  end
endmodule
